// ---- core/opm_pkg.sv ----
package opm_pkg;

  // ---------------------------------------------------------------------------
  // Register indices. The byte address of a register is four times its index.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OPM_IDX_INPUT_CONTROL    = 8'h00;
  localparam logic [7:0] OPM_IDX_VIDEO_SELECTION  = 8'h01;
  localparam logic [7:0] OPM_IDX_VIDEO_ENHANCE    = 8'h02;
  localparam logic [7:0] OPM_IDX_OUTPUT_CONTROL   = 8'h03;
  localparam logic [7:0] OPM_IDX_EXT_OUTPUT_CTRL  = 8'h04;
  localparam logic [7:0] OPM_IDX_GP_OUTPUT        = 8'h05;
  localparam logic [7:0] OPM_IDX_RESERVED_06      = 8'h06;
  localparam logic [7:0] OPM_IDX_FIFO_CONTROL     = 8'h07;
  localparam logic [7:0] OPM_IDX_CONTRAST         = 8'h08;
  localparam logic [7:0] OPM_IDX_SATURATION       = 8'h09;
  localparam logic [7:0] OPM_IDX_BRIGHTNESS       = 8'h0a;
  localparam logic [7:0] OPM_IDX_HUE              = 8'h0b;
  localparam logic [7:0] OPM_IDX_DEFAULT_LUMA     = 8'h0c;
  localparam logic [7:0] OPM_IDX_DEFAULT_CHROMA   = 8'h0d;
  localparam logic [7:0] OPM_IDX_TEMPORAL_DECIM   = 8'h0e;
  localparam logic [7:0] OPM_IDX_POWER_MANAGEMENT = 8'h0f;
  localparam logic [7:0] OPM_IDX_DECODER_STATUS   = 8'h10;
  localparam logic [7:0] OPM_IDX_DECODER_INFO     = 8'h11;
  localparam logic [7:0] OPM_IDX_OUTPUT_POLARITY  = 8'h37;
  localparam logic [7:0] OPM_IDX_RESAMPLE_CONTROL = 8'h44;
  localparam logic [7:0] OPM_IDX_RESERVED_45      = 8'h45;
  localparam logic [7:0] OPM_IDX_RESERVED_F1      = 8'hf1;
  localparam logic [7:0] OPM_IDX_RESERVED_F2      = 8'hf2;

  // Number of registers in the basic block, indices 0 to 15.
  localparam int         OPM_BASIC_COUNT          = 16;

  // ---------------------------------------------------------------------------
  // Values after reset.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OPM_BASIC_RESET [OPM_BASIC_COUNT] = '{
    8'h00, 8'h80, 8'h04, 8'h0c, 8'h0c, 8'h40, 8'h00, 8'h04,
    8'h80, 8'h80, 8'h00, 8'h00, 8'h10, 8'h88, 8'h00, 8'h00
  };
  localparam logic [7:0]  OPM_RST_OUTPUT_POLARITY  = 8'h00;
  localparam logic [7:0]  OPM_RST_RESAMPLE_CONTROL = 8'h01;
  localparam logic [7:0]  OPM_RST_RESERVED_45      = 8'h23;
  localparam logic [7:0]  OPM_RST_RESERVED_F1      = 8'hf6;
  localparam logic [7:0]  OPM_RST_RESERVED_F2      = 8'h9c;
  localparam logic [31:0] OPM_RDATA_RESET          = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int OPM_POL_PIXEL_CLOCK    = 0;
  localparam int OPM_POL_FIFO_FLAG      = 1;
  localparam int OPM_POL_DATA_FIELD     = 2;
  localparam int OPM_POL_FIELD_SYNC     = 3;
  localparam int OPM_POL_CLOCK_REF      = 4;
  localparam int OPM_POL_VERTICAL_SYNC  = 5;
  localparam int OPM_POL_REFERENCE_SYNC = 6;
  localparam int OPM_POL_HORIZ_SYNC     = 7;
  localparam int OPM_RSMP_LOCK_INVERT   = 6;

  // Number of invertible outputs: 13 under the polarity register plus the genlock bit.
  localparam int OPM_SIG_COUNT          = 14;

endpackage : opm_pkg

// ---- core/opm_output_polarity_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// RQ1: Polarity bit 0 inverts all three pixel clocks.
// RQ2: Polarity bit 1 inverts the three FIFO flags.
// RQ3: Polarity bit 2 inverts the data-field output.
// RQ4: Polarity bit 3 inverts the field sync output.
// RQ5: Polarity bit 4 inverts the clock reference output.
// RQ6: Polarity bit 5 inverts the vertical sync output.
// RQ7: Polarity bit 6 inverts both reference outputs together.
// RQ8: Polarity bit 7 inverts the horizontal sync output.
// RQ9: Resample bit 6 inverts the genlock bit.
// RQ10: Software keeps resample bits at default pattern.
// RQ11: Software writes reserved 0x45 with fixed pattern.
// RQ12: Software writes reserved 0xF1 with fixed pattern.
// RQ13: Software writes reserved 0xF2 with fixed pattern.
// RQ14: Polarity register resets to zero, outputs active high.
// RQ15: Polarity only inverts; timing stays unchanged.
module opm_output_polarity_regs #(
  parameter int HADDR_W = 12
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic               hsel,
  input  wire logic [HADDR_W-1:0] haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [7:0]         decoder_status_in,
  input  wire logic [7:0]         decoder_info_in,
  input  wire logic               line_locked_clock_in,
  input  wire logic               half_rate_line_clock_in,
  input  wire logic               qualifying_clock_in,
  input  wire logic               fifo_half_full_in,
  input  wire logic               fifo_almost_empty_in,
  input  wire logic               fifo_almost_full_in,
  input  wire logic               data_field_in,
  input  wire logic               field_sync_in,
  input  wire logic               line_clock_reference_in,
  input  wire logic               vertical_sync_in,
  input  wire logic               horizontal_reference_in,
  input  wire logic               vertical_reference_in,
  input  wire logic               horizontal_sync_in,
  input  wire logic               genlock_bit_in,
  output logic                    line_locked_clock_out,
  output logic                    half_rate_line_clock_out,
  output logic                    qualifying_clock_out,
  output logic                    fifo_half_full_out,
  output logic                    fifo_almost_empty_out,
  output logic                    fifo_almost_full_out,
  output logic                    data_field_out,
  output logic                    field_sync_out,
  output logic                    line_clock_reference_out,
  output logic                    vertical_sync_out,
  output logic                    horizontal_reference_out,
  output logic                    vertical_reference_out,
  output logic                    horizontal_sync_out,
  output logic                    realtime_control_genlock_out,
  output logic      [7:0]         input_control,
  output logic      [7:0]         video_selection,
  output logic      [7:0]         video_enhancement_control,
  output logic      [7:0]         output_control,
  output logic      [7:0]         extended_output_control,
  output logic      [7:0]         general_purpose_output,
  output logic      [7:0]         fifo_control,
  output logic      [7:0]         contrast_control,
  output logic      [7:0]         saturation_control,
  output logic      [7:0]         brightness_control,
  output logic      [7:0]         hue_control,
  output logic      [7:0]         default_luma_value,
  output logic      [7:0]         default_chroma_value,
  output logic      [7:0]         temporal_decimation,
  output logic      [7:0]         power_management
);

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic [7:0]  basic_q [opm_pkg::OPM_BASIC_COUNT];
  logic [7:0]  output_polarity_q;
  logic [7:0]  resample_control_q;
  logic [7:0]  reserved_45_q;
  logic [7:0]  reserved_f1_q;
  logic [7:0]  reserved_f2_q;
  logic        wr_pend_q;
  logic [7:0]  wr_idx_q;
  logic        wr_ok_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;

  wire        addr_phase = hsel & hready & htrans[1];
  wire        idx_mapped = (haddr[HADDR_W-1:10] == '0);
  wire [7:0]  rd_idx     = haddr[9:2];
  wire        rd_basic   = (rd_idx[7:4] == 4'h0);

  // Writes to read-only or reserved-empty locations are dropped silently.
  wire        idx_writable =
      idx_mapped & ((rd_basic & (rd_idx != opm_pkg::OPM_IDX_RESERVED_06)) |
                    (rd_idx == opm_pkg::OPM_IDX_OUTPUT_POLARITY) |
                    (rd_idx == opm_pkg::OPM_IDX_RESAMPLE_CONTROL) |
                    (rd_idx == opm_pkg::OPM_IDX_RESERVED_45) |
                    (rd_idx == opm_pkg::OPM_IDX_RESERVED_F1) |
                    (rd_idx == opm_pkg::OPM_IDX_RESERVED_F2));

  wire        wr_en      = wr_pend_q & wr_ok_q;
  wire [7:0]  wr_data    = hwdata[7:0];

  wire [7:0]  rd_stored  =
      !idx_mapped                                      ? 8'h00 :
      rd_basic                                         ? basic_q[rd_idx[3:0]] :
      (rd_idx == opm_pkg::OPM_IDX_DECODER_STATUS)      ? decoder_status_in :
      (rd_idx == opm_pkg::OPM_IDX_DECODER_INFO)        ? decoder_info_in :
      (rd_idx == opm_pkg::OPM_IDX_OUTPUT_POLARITY)     ? output_polarity_q :
      (rd_idx == opm_pkg::OPM_IDX_RESAMPLE_CONTROL)    ? resample_control_q :
      (rd_idx == opm_pkg::OPM_IDX_RESERVED_45)         ? reserved_45_q :
      (rd_idx == opm_pkg::OPM_IDX_RESERVED_F1)         ? reserved_f1_q :
      (rd_idx == opm_pkg::OPM_IDX_RESERVED_F2)         ? reserved_f2_q :
                                                         8'h00;

  // A pipelined master may read a register in the cycle its write data lands.
  wire        rd_forward = wr_en & (wr_idx_q == rd_idx) & idx_mapped;
  wire [7:0]  rd_val     = rd_forward ? wr_data : rd_stored;

  // ---------------------------------------------------------------------------
  // Bus slave state
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
      wr_ok_q   <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_idx_q <= rd_idx;
        wr_ok_q  <= idx_writable;
      end
    end
  end

  // Read data is sampled at the end of the address phase so that hrdata comes
  // straight from a flip-flop and the slave still answers with no wait state.
  always_ff @(posedge clock) begin
    if (reset) begin
      hrdata_q    <= opm_pkg::OPM_RDATA_RESET;
      hreadyout_q <= 1'b0;
    end else begin
      hrdata_q    <= (addr_phase & ~hwrite) ? {24'h00_0000, rd_val} : opm_pkg::OPM_RDATA_RESET;
      hreadyout_q <= 1'b1;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < opm_pkg::OPM_BASIC_COUNT; i++) begin : g_basic
    wire hit = wr_en & (wr_idx_q == 8'(i)) & (8'(i) != opm_pkg::OPM_IDX_RESERVED_06);
    always_ff @(posedge clock) begin
      if (reset) begin
        basic_q[i] <= opm_pkg::OPM_BASIC_RESET[i];
      end else if (hit) begin
        basic_q[i] <= wr_data;
      end
    end
  end

  wire wr_pol  = wr_en & (wr_idx_q == opm_pkg::OPM_IDX_OUTPUT_POLARITY);
  wire wr_rsmp = wr_en & (wr_idx_q == opm_pkg::OPM_IDX_RESAMPLE_CONTROL);
  wire wr_r45  = wr_en & (wr_idx_q == opm_pkg::OPM_IDX_RESERVED_45);
  wire wr_rf1  = wr_en & (wr_idx_q == opm_pkg::OPM_IDX_RESERVED_F1);
  wire wr_rf2  = wr_en & (wr_idx_q == opm_pkg::OPM_IDX_RESERVED_F2);

  // The reserved registers store whatever software writes; keeping the fixed
  // patterns in them is the driver's duty, the hardware does not enforce it.
  always_ff @(posedge clock) begin
    if (reset) begin
      output_polarity_q  <= opm_pkg::OPM_RST_OUTPUT_POLARITY; // RQ14
      resample_control_q <= opm_pkg::OPM_RST_RESAMPLE_CONTROL;
      reserved_45_q      <= opm_pkg::OPM_RST_RESERVED_45;
      reserved_f1_q      <= opm_pkg::OPM_RST_RESERVED_F1;
      reserved_f2_q      <= opm_pkg::OPM_RST_RESERVED_F2;
    end else begin
      if (wr_pol) output_polarity_q <= wr_data;
      if (wr_rsmp) resample_control_q <= wr_data;
      if (wr_r45) reserved_45_q <= wr_data;
      if (wr_rf1) reserved_f1_q <= wr_data;
      if (wr_rf2) reserved_f2_q <= wr_data;
    end
  end

  assign input_control             = basic_q[opm_pkg::OPM_IDX_INPUT_CONTROL[3:0]];
  assign video_selection           = basic_q[opm_pkg::OPM_IDX_VIDEO_SELECTION[3:0]];
  assign video_enhancement_control = basic_q[opm_pkg::OPM_IDX_VIDEO_ENHANCE[3:0]];
  assign output_control            = basic_q[opm_pkg::OPM_IDX_OUTPUT_CONTROL[3:0]];
  assign extended_output_control   = basic_q[opm_pkg::OPM_IDX_EXT_OUTPUT_CTRL[3:0]];
  assign general_purpose_output    = basic_q[opm_pkg::OPM_IDX_GP_OUTPUT[3:0]];
  assign fifo_control              = basic_q[opm_pkg::OPM_IDX_FIFO_CONTROL[3:0]];
  assign contrast_control          = basic_q[opm_pkg::OPM_IDX_CONTRAST[3:0]];
  assign saturation_control        = basic_q[opm_pkg::OPM_IDX_SATURATION[3:0]];
  assign brightness_control        = basic_q[opm_pkg::OPM_IDX_BRIGHTNESS[3:0]];
  assign hue_control               = basic_q[opm_pkg::OPM_IDX_HUE[3:0]];
  assign default_luma_value        = basic_q[opm_pkg::OPM_IDX_DEFAULT_LUMA[3:0]];
  assign default_chroma_value      = basic_q[opm_pkg::OPM_IDX_DEFAULT_CHROMA[3:0]];
  assign temporal_decimation       = basic_q[opm_pkg::OPM_IDX_TEMPORAL_DECIM[3:0]];
  assign power_management          = basic_q[opm_pkg::OPM_IDX_POWER_MANAGEMENT[3:0]];

  // ---------------------------------------------------------------------------
  // Output polarity stage
  // ---------------------------------------------------------------------------
  logic [opm_pkg::OPM_SIG_COUNT-1:0] sig_raw;
  logic [opm_pkg::OPM_SIG_COUNT-1:0] sig_pol;
  logic [opm_pkg::OPM_SIG_COUNT-2:0] sig_q;
  logic                              genlock_q;

  assign sig_raw[12:0] = {horizontal_sync_in, vertical_reference_in, horizontal_reference_in,
                          vertical_sync_in, line_clock_reference_in, field_sync_in, data_field_in,
                          fifo_almost_full_in, fifo_almost_empty_in, fifo_half_full_in,
                          qualifying_clock_in, half_rate_line_clock_in, line_locked_clock_in};

  assign sig_pol[2:0]   = {3{output_polarity_q[opm_pkg::OPM_POL_PIXEL_CLOCK]}};    // RQ1
  assign sig_pol[5:3]   = {3{output_polarity_q[opm_pkg::OPM_POL_FIFO_FLAG]}};      // RQ2
  assign sig_pol[6]     = output_polarity_q[opm_pkg::OPM_POL_DATA_FIELD];          // RQ3
  assign sig_pol[7]     = output_polarity_q[opm_pkg::OPM_POL_FIELD_SYNC];          // RQ4
  assign sig_pol[8]     = output_polarity_q[opm_pkg::OPM_POL_CLOCK_REF];           // RQ5
  assign sig_pol[9]     = output_polarity_q[opm_pkg::OPM_POL_VERTICAL_SYNC];       // RQ6
  assign sig_pol[11:10] = {2{output_polarity_q[opm_pkg::OPM_POL_REFERENCE_SYNC]}}; // RQ7
  assign sig_pol[12]    = output_polarity_q[opm_pkg::OPM_POL_HORIZ_SYNC];          // RQ8

  // Every path, inverted or not, has the same single flip-flop of latency, so
  // a change of polarity never shifts an edge relative to the others.
  for (genvar s = 0; s < opm_pkg::OPM_SIG_COUNT - 1; s++) begin : g_pol
    always_ff @(posedge clock) begin
      if (reset) begin
        sig_q[s] <= 1'b0;
      end else begin
        sig_q[s] <= sig_raw[s] ^ sig_pol[s]; // RQ15
      end
    end
  end

  assign sig_raw[13] = genlock_bit_in;
  assign sig_pol[13] = resample_control_q[opm_pkg::OPM_RSMP_LOCK_INVERT];

  always_ff @(posedge clock) begin
    if (reset) begin
      genlock_q <= 1'b0;
    end else begin
      genlock_q <= sig_raw[13] ^ sig_pol[13]; // RQ9
    end
  end

  assign line_locked_clock_out        = sig_q[0];
  assign half_rate_line_clock_out     = sig_q[1];
  assign qualifying_clock_out         = sig_q[2];
  assign fifo_half_full_out           = sig_q[3];
  assign fifo_almost_empty_out        = sig_q[4];
  assign fifo_almost_full_out         = sig_q[5];
  assign data_field_out               = sig_q[6];
  assign field_sync_out               = sig_q[7];
  assign line_clock_reference_out     = sig_q[8];
  assign vertical_sync_out            = sig_q[9];
  assign horizontal_reference_out     = sig_q[10];
  assign vertical_reference_out       = sig_q[11];
  assign horizontal_sync_out          = sig_q[12];
  assign realtime_control_genlock_out = genlock_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_pixel_clock_pol : assert property ( // RQ1
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> (line_locked_clock_out == ($past(line_locked_clock_in) ^ $past(output_polarity_q[0])))
                   && (half_rate_line_clock_out == ($past(half_rate_line_clock_in) ^ $past(output_polarity_q[0])))
                   && (qualifying_clock_out == ($past(qualifying_clock_in) ^ $past(output_polarity_q[0]))))
    else $error("Pixel clock output does not follow polarity bit 0.");

  a_fifo_flag_pol : assert property ( // RQ2
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> (fifo_half_full_out == ($past(fifo_half_full_in) ^ $past(output_polarity_q[1])))
                   && (fifo_almost_empty_out == ($past(fifo_almost_empty_in) ^ $past(output_polarity_q[1])))
                   && (fifo_almost_full_out == ($past(fifo_almost_full_in) ^ $past(output_polarity_q[1]))))
    else $error("FIFO flags do not follow polarity bit 1.");

  a_data_field_pol : assert property ( // RQ3
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> data_field_out == ($past(data_field_in) ^ $past(output_polarity_q[2])))
    else $error("Data-field output does not follow polarity bit 2.");

  a_field_sync_pol : assert property ( // RQ4
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> field_sync_out == ($past(field_sync_in) ^ $past(output_polarity_q[3])))
    else $error("Field sync does not follow polarity bit 3.");

  a_clock_ref_pol : assert property ( // RQ5
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> line_clock_reference_out == ($past(line_clock_reference_in) ^ $past(output_polarity_q[4])))
    else $error("Clock reference does not follow polarity bit 4.");

  a_vsync_pol : assert property ( // RQ6
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> vertical_sync_out == ($past(vertical_sync_in) ^ $past(output_polarity_q[5])))
    else $error("Vertical sync does not follow polarity bit 5.");

  a_reference_pol : assert property ( // RQ7
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> ((horizontal_reference_out ^ $past(horizontal_reference_in)) == $past(output_polarity_q[6]))
                   && ((vertical_reference_out ^ $past(vertical_reference_in)) == $past(output_polarity_q[6])))
    else $error("Reference outputs do not both follow polarity bit 6.");

  a_hsync_pol : assert property ( // RQ8
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> horizontal_sync_out == ($past(horizontal_sync_in) ^ $past(output_polarity_q[7])))
    else $error("Horizontal sync does not follow polarity bit 7.");

  a_genlock_invert : assert property ( // RQ9
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> realtime_control_genlock_out == ($past(genlock_bit_in) ^ $past(resample_control_q[6])))
    else $error("Genlock bit does not follow resample bit 6.");

  a_polarity_reset : assert property ( // RQ14
    @(posedge clock) disable iff (reset)
    $past(reset) |-> (output_polarity_q == 8'h00) && !hrdata[0])
    else $error("Polarity register not zero after reset.");

  // Two consecutive samples under a steady polarity show each horizontal sync edge leaving one cycle after it arrives.
  a_edge_timing : assert property ( // RQ15
    @(posedge clock) disable iff (reset)
    (!$past(reset, 2) && !$past(reset) && ($past(output_polarity_q) == $past(output_polarity_q, 2))) |->
      ((horizontal_sync_out != $past(horizontal_sync_out)) ==
       ($past(horizontal_sync_in) != $past(horizontal_sync_in, 2))))
    else $error("Horizontal sync edge moved relative to its source.");

  a_ready_no_wait : assert property (
    @(posedge clock) disable iff (reset)
    !$past(reset) |-> hreadyout)
    else $error("Slave held off a transfer after reset.");

  a_read_data_idle : assert property (
    @(posedge clock) disable iff (reset)
    (!$past(reset) && !$past(addr_phase & ~hwrite)) |-> (hrdata == opm_pkg::OPM_RDATA_RESET))
    else $error("Read data not zero outside a read data phase.");

  // A read in the data phase of a write to the same index must already see the new byte.
  a_write_forward : assert property (
    @(posedge clock) disable iff (reset)
    (!$past(reset) && $past(addr_phase & ~hwrite & rd_forward)) |-> (hrdata[7:0] == $past(hwdata[7:0])))
    else $error("Read after write to the same index returned stale data.");

  a_status_live : assert property (
    @(posedge clock) disable iff (reset)
    (!$past(reset) && $past(addr_phase & ~hwrite & idx_mapped) &&
     ($past(rd_idx) == opm_pkg::OPM_IDX_DECODER_STATUS)) |-> (hrdata[7:0] == $past(decoder_status_in)))
    else $error("Status read does not return the live status input.");

  a_polarity_store : assert property (
    @(posedge clock) disable iff (reset)
    (!$past(reset) && $past(wr_pol)) |-> (output_polarity_q == $past(hwdata[7:0])))
    else $error("Polarity register did not take the written byte.");

  a_resample_store : assert property (
    @(posedge clock) disable iff (reset)
    (!$past(reset) && $past(wr_rsmp)) |-> (resample_control_q == $past(hwdata[7:0])))
    else $error("Resample register did not take the written byte.");

endmodule : opm_output_polarity_regs

// ---- dv/opm_sync_sink.sv ----
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Downstream sink that folds the programmed polarity back out of each output.
// -----------------------------------------------------------------------------
module opm_sync_sink (
  input  wire logic        clock,
  input  wire logic [13:0] sync_in,
  input  wire logic [7:0]  pol,
  input  wire logic        lock_inv,
  output logic      [13:0] recovered
);
  localparam int POL_BIT [13] = '{0, 0, 0, 1, 1, 1, 2, 3, 4, 5, 6, 6, 7};
  // One register stage, so rec follows src two cycles later when the block adds its single cycle.
  always_ff @(posedge clock) begin
    for (int i = 0; i < 13; i++) begin
      recovered[i] <= sync_in[i] ^ pol[POL_BIT[i]];
    end
    recovered[13] <= sync_in[13] ^ lock_inv;
  end
endmodule : opm_sync_sink

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clock = 1'b0, reset = 1'b1, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0000_0000, rd, w;
  logic [13:0] src = 14'h0000;
  logic [7:0]  stat = 8'h00, pol = 8'h00, rsmp = 8'h01, p;
  wire  [31:0] hrdata;
  wire         hready, hresp;
  wire  [13:0] outs, rec;
  wire  [15:0][7:0] bo;
  int          mismatches = 0, tests_run = 0;
  localparam logic [7:0] RSV_IDX [3] = '{8'h45, 8'hf1, 8'hf2};
  localparam logic [7:0] RSV_VAL [3] = '{8'hbb, 8'hef, 8'h80};
  localparam logic [7:0] RSV_RST [3] = '{opm_pkg::OPM_RST_RESERVED_45, opm_pkg::OPM_RST_RESERVED_F1,
                                         opm_pkg::OPM_RST_RESERVED_F2};

  opm_output_polarity_regs #(.HADDR_W(12)) u_dut (
    .clock(clock), .reset(reset), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .decoder_status_in(stat), .decoder_info_in(~stat),
    .line_locked_clock_in(src[0]), .half_rate_line_clock_in(src[1]), .qualifying_clock_in(src[2]),
    .fifo_half_full_in(src[3]), .fifo_almost_empty_in(src[4]), .fifo_almost_full_in(src[5]),
    .data_field_in(src[6]), .field_sync_in(src[7]), .line_clock_reference_in(src[8]),
    .vertical_sync_in(src[9]), .horizontal_reference_in(src[10]), .vertical_reference_in(src[11]),
    .horizontal_sync_in(src[12]), .genlock_bit_in(src[13]),
    .line_locked_clock_out(outs[0]), .half_rate_line_clock_out(outs[1]), .qualifying_clock_out(outs[2]),
    .fifo_half_full_out(outs[3]), .fifo_almost_empty_out(outs[4]), .fifo_almost_full_out(outs[5]),
    .data_field_out(outs[6]), .field_sync_out(outs[7]), .line_clock_reference_out(outs[8]),
    .vertical_sync_out(outs[9]), .horizontal_reference_out(outs[10]), .vertical_reference_out(outs[11]),
    .horizontal_sync_out(outs[12]), .realtime_control_genlock_out(outs[13]),
    .input_control(bo[0]), .video_selection(bo[1]), .video_enhancement_control(bo[2]), .output_control(bo[3]),
    .extended_output_control(bo[4]), .general_purpose_output(bo[5]), .fifo_control(bo[7]), .contrast_control(bo[8]),
    .saturation_control(bo[9]), .brightness_control(bo[10]), .hue_control(bo[11]), .default_luma_value(bo[12]),
    .default_chroma_value(bo[13]), .temporal_decimation(bo[14]), .power_management(bo[15])
  );
  assign bo[6] = 8'h00;

  opm_sync_sink u_sink (.clock(clock), .sync_in(outs), .pol(pol), .lock_inv(rsmp[6]), .recovered(rec));

  initial begin
    forever #2 clock = ~clock;
  end

  function automatic logic [13:0] expect_out(logic [13:0] s, logic [7:0] q, logic [7:0] r);
    expect_out = s ^ {r[6], q[7], {2{q[6]}}, q[5], q[4], q[3], q[2], {3{q[1]}}, {3{q[0]}}};
  endfunction : expect_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One single word transfer; the wait loops lean on the watchdog for a hang.
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr  <= {2'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  initial begin
    #40000;
    mismatches++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h0000_a624));
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 16; i++) begin
      bus(8'(i), 1'b0, 32'h0000_0000);
      check(rd, {24'h00_0000, opm_pkg::OPM_BASIC_RESET[i]});
      check(32'(bo[i]), 32'(opm_pkg::OPM_BASIC_RESET[i]));
    end
    bus(8'h37, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    bus(8'h44, 1'b0, 32'h0000_0000);
    check(rd, 32'(opm_pkg::OPM_RST_RESAMPLE_CONTROL));
    for (int i = 0; i < 3; i++) begin
      bus(RSV_IDX[i], 1'b0, 32'h0000_0000);
      check(rd, 32'(RSV_RST[i]));
      bus(RSV_IDX[i], 1'b1, {24'h00_0000, RSV_VAL[i]});
      bus(RSV_IDX[i], 1'b0, 32'h0000_0000);
      check(rd, {24'h00_0000, RSV_VAL[i]});
    end
    bus(8'h20, 1'b1, 32'hffff_ffff);
    bus(8'h20, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(hresp), 32'h0000_0000);
    stat <= 8'($urandom);
    bus(8'h10, 1'b1, 32'hffff_ffff);
    bus(8'h10, 1'b0, 32'h0000_0000);
    check(rd, {24'h00_0000, stat});
    bus(8'h11, 1'b0, 32'h0000_0000);
    check(rd, {24'h00_0000, ~stat});
    w = $urandom;
    bus(8'h08, 1'b1, w);
    bus(8'h08, 1'b0, 32'h0000_0000);
    check(rd, {24'h00_0000, w[7:0]});
    check(32'(bo[8]), {24'h00_0000, w[7:0]});
    // Walk each polarity bit alone, then random mixes with the lock inversion toggling.
    for (int i = 0; i < 24; i++) begin
      p = (i < 8) ? (8'h01 << i) : 8'($urandom);
      pol <= p;
      bus(8'h37, 1'b1, {24'h00_0000, p});
      rsmp <= {1'b0, i[0], 6'h01};
      bus(8'h44, 1'b1, {24'h00_0000, 1'b0, i[0], 6'h01});
      src <= 14'($urandom);
      repeat (3) @(posedge clock);
      check(32'(outs), 32'(expect_out(src, pol, rsmp)));
      check(32'(rec), 32'(src));
      src <= 14'($urandom);
      repeat (2) @(posedge clock);
      check(32'(outs), 32'(expect_out(src, pol, rsmp)));
      bus(8'h37, 1'b0, 32'h0000_0000);
      check(rd, {24'h00_0000, p});
    end
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    bus(8'h37, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    complete_run();
  end
endmodule : tb
